//--- hw/hmvwf_core.sv
// Tag classification, length limit and wake-up control of the host MAC.
// Assumes a classic Wishbone master, a receive byte stream and pattern
// matchers on core_clk; resets other than arst_n are same-clock pulses.
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
module hmvwf_core
   import hmvwf_pkg::*;
#(
   parameter int FILTER_DEPTH = 8,
   parameter int WB_ADR_W = 8
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic digital_rst,
   input wire logic soft_rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [WB_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_last,
   input wire logic magic_packet_seen,
   input wire logic wake_frame_seen,
   output logic tag_one_frame,
   output logic tag_two_frame,
   output logic [LEN_W-1:0] max_frame_len,
   output logic frame_too_long,
   output logic wake_frame_detect_enable,
   output logic magic_packet_wake_enable,
   output logic [FILTER_DEPTH*32-1:0] wake_filter_words,
   output logic wake_request,
   output logic irq
);
   localparam int PTR_W = $clog2(FILTER_DEPTH);

   typedef enum logic {HMVWF_IDLE, HMVWF_ACK} hmvwf_bus_t;

   hmvwf_bus_t bus_state;
   logic [15:0] first_tag_identifier, second_tag_identifier;
   logic [31:0] wake_filter_word [FILTER_DEPTH];
   logic [PTR_W-1:0] filter_ptr;
   logic global_unicast_wake_enable;
   logic wake_frame_received_flag;
   logic magic_packet_received_flag;
   logic [IRQ_W-1:0] irq_status, irq_mask;
   logic [LEN_W-1:0] byte_count, frame_len;
   logic [7:0] tag_hi;
   logic da_group_bit, wr_en, tag_lo_seen;
   logic [5:0] reg_idx;
   logic [31:0] next_rdata;
   logic magic_set, wframe_set, unicast_hit, len_err_hit;
   logic [15:0] rx_tag;

   // Byte-lane merge used by the tag registers and the filter entries
   function automatic logic [31:0] merge_sel(input logic [31:0] old_val,
                                             input logic [31:0] new_val,
                                             input logic [3:0] sel);
      logic [31:0] res;
      res = old_val;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[i*8 +: 8] = new_val[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // Write one to clear, with a same-cycle set winning
   function automatic logic sticky(input logic cur, input logic set,
                                   input logic clr);
      return set | (cur & ~clr);
   endfunction

   assign reg_idx = wb_adr_i[ADR_LSB +: 6];
   // Writes land on the edge at which the master sees ack
   assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

   // One wait cycle, then ack for one cycle
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         bus_state <= HMVWF_IDLE;
      end else begin
         case (bus_state)
            HMVWF_IDLE: begin
               if (wb_cyc_i && wb_stb_i) begin
                  bus_state <= HMVWF_ACK;
               end
            end
            HMVWF_ACK: bus_state <= HMVWF_IDLE;
            default: bus_state <= HMVWF_IDLE;
         endcase
      end
   end

   assign wb_ack_o = (bus_state == HMVWF_ACK);

   always_comb begin
      next_rdata = 32'h0000_0000;
      case (reg_idx)
         IDX_VLAN_TAG_ONE: next_rdata[TAG_W-1:0] = first_tag_identifier;
         IDX_VLAN_TAG_TWO: next_rdata[TAG_W-1:0] = second_tag_identifier;
         IDX_WAKE_FILTER_LOAD: next_rdata = 32'h0000_0000;
         IDX_WAKE_CONTROL_STATUS: begin
            next_rdata[GUE_BIT] = global_unicast_wake_enable;
            next_rdata[WAKE_FRAME_RECEIVED_FLAG_BIT] = wake_frame_received_flag;
            next_rdata[MPR_BIT] = magic_packet_received_flag;
            next_rdata[WAKE_FRAME_DETECT_ENABLE_BIT] = wake_frame_detect_enable;
            next_rdata[MAGIC_PACKET_WAKE_ENABLE_BIT] = magic_packet_wake_enable;
         end
         IDX_IRQ_STATUS: next_rdata[IRQ_W-1:0] = irq_status;
         IDX_IRQ_MASK: next_rdata[IRQ_W-1:0] = irq_mask;
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (bus_state == HMVWF_IDLE && wb_cyc_i && wb_stb_i) begin
         wb_dat_o <= wb_we_i ? 32'h0000_0000 : next_rdata;
      end
   end

   // Tag registers
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         first_tag_identifier <= TAG_RESET;
         second_tag_identifier <= TAG_RESET;
      end else if (wr_en) begin
         if (reg_idx == IDX_VLAN_TAG_ONE) begin
            first_tag_identifier <= TAG_W'(merge_sel({16'h0000,
               first_tag_identifier}, wb_dat_i, wb_sel_i));
         end
         if (reg_idx == IDX_VLAN_TAG_TWO) begin
            second_tag_identifier <= TAG_W'(merge_sel({16'h0000,
               second_tag_identifier}, wb_dat_i, wb_sel_i));
         end
      end
   end

   // Filter entries; contents have no reset, pointer does
   always_ff @(posedge core_clk) begin
      if (wr_en && reg_idx == IDX_WAKE_FILTER_LOAD) begin
         wake_filter_word[filter_ptr] <= merge_sel(wake_filter_word[filter_ptr],
            wb_dat_i, wb_sel_i);
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         filter_ptr <= '0;
      end else if (digital_rst || soft_rst) begin
         filter_ptr <= '0;
      end else if (wr_en && reg_idx == IDX_WAKE_FILTER_LOAD) begin
         if (filter_ptr == PTR_W'(FILTER_DEPTH - 1)) begin
            filter_ptr <= '0;
         end else begin
            filter_ptr <= filter_ptr + PTR_W'(1);
         end
      end
   end

   for (genvar g = 0; g < FILTER_DEPTH; g++) begin : g_filt
      assign wake_filter_words[g*32 +: 32] = wake_filter_word[g];
   end

   // Wake control bits
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         global_unicast_wake_enable <= 1'b0;
         wake_frame_detect_enable <= 1'b0;
         magic_packet_wake_enable <= 1'b0;
      end else if (wr_en && reg_idx == IDX_WAKE_CONTROL_STATUS) begin
         if (wb_sel_i[1]) begin
            global_unicast_wake_enable <= wb_dat_i[GUE_BIT];
         end
         if (wb_sel_i[0]) begin
            wake_frame_detect_enable <= wb_dat_i[WAKE_FRAME_DETECT_ENABLE_BIT];
            magic_packet_wake_enable <= wb_dat_i[MAGIC_PACKET_WAKE_ENABLE_BIT];
         end
      end
   end

   // Detection only counts while its enable is set
   assign wframe_set = wake_frame_seen & wake_frame_detect_enable;
   assign magic_set = magic_packet_seen & magic_packet_wake_enable;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         wake_frame_received_flag <= 1'b0;
         magic_packet_received_flag <= 1'b0;
      end else begin
         wake_frame_received_flag <= sticky(wake_frame_received_flag,
            wframe_set, wr_en && reg_idx == IDX_WAKE_CONTROL_STATUS &&
            wb_sel_i[0] && wb_dat_i[WAKE_FRAME_RECEIVED_FLAG_BIT]);
         magic_packet_received_flag <= sticky(magic_packet_received_flag,
            magic_set, wr_en && reg_idx == IDX_WAKE_CONTROL_STATUS &&
            wb_sel_i[0] && wb_dat_i[MPR_BIT]);
      end
   end

   // Receive byte position; saturates so giant frames stay too long
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         byte_count <= '0;
      end else if (rx_valid) begin
         if (rx_last) begin
            byte_count <= '0;
         end else if (byte_count != LEN_CAP) begin
            byte_count <= byte_count + LEN_W'(1);
         end
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         tag_hi <= 8'h00;
         da_group_bit <= 1'b0;
      end else if (rx_valid) begin
         if (byte_count == POS_TAG_HI) begin
            tag_hi <= rx_data;
         end
         if (byte_count == POS_DA_FIRST) begin
            da_group_bit <= rx_data[0];
         end
      end
   end

   assign tag_lo_seen = rx_valid && byte_count == POS_TAG_LO;
   assign rx_tag = {tag_hi, rx_data};

   // Classification holds until the next frame begins
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         tag_one_frame <= 1'b0;
         tag_two_frame <= 1'b0;
      end else if (rx_valid && byte_count == POS_DA_FIRST) begin
         tag_one_frame <= 1'b0;
         tag_two_frame <= 1'b0;
      end else if (tag_lo_seen) begin
         tag_one_frame <= rx_tag == first_tag_identifier;
         tag_two_frame <= rx_tag == second_tag_identifier &&
            rx_tag != first_tag_identifier;
      end
   end

   // First tag wins when both identifiers hold one value
   assign max_frame_len = tag_one_frame ? LEN_TAG_ONE :
      tag_two_frame ? LEN_TAG_TWO : LEN_PLAIN;
   assign frame_len = (byte_count == LEN_CAP) ? LEN_CAP :
      byte_count + LEN_W'(1);
   assign len_err_hit = rx_valid && rx_last && frame_len > max_frame_len;
   assign unicast_hit = rx_valid && rx_last && global_unicast_wake_enable &&
      !da_group_bit;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         frame_too_long <= 1'b0;
         wake_request <= 1'b0;
      end else begin
         frame_too_long <= len_err_hit;
         wake_request <= unicast_hit | magic_set | wframe_set;
      end
   end

   // Interrupt status, write one to clear, set wins
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_status <= '0;
         irq_mask <= '0;
      end else begin
         for (int i = 0; i < IRQ_W; i++) begin
            irq_status[i] <= sticky(irq_status[i],
               (i == IRQ_MAGIC && magic_set) ||
               (i == IRQ_WAKE_FRAME && wframe_set) ||
               (i == IRQ_UNICAST && unicast_hit) ||
               (i == IRQ_LEN_ERR && len_err_hit),
               wr_en && reg_idx == IDX_IRQ_STATUS && wb_sel_i[0] &&
               wb_dat_i[i]);
         end
         if (wr_en && reg_idx == IDX_IRQ_MASK && wb_sel_i[0]) begin
            irq_mask <= wb_dat_i[IRQ_W-1:0];
         end
      end
   end

   assign irq = |(irq_status & irq_mask);

   property p_tag_one;
      @(posedge core_clk) disable iff (!arst_n)
         tag_lo_seen && !(rx_valid && byte_count == POS_DA_FIRST) &&
         {tag_hi, rx_data} == first_tag_identifier |=> tag_one_frame;
   endproperty
   a_tag_one: assert property (p_tag_one)
      else $error("first tag match not flagged");
   property p_len_one;
      @(posedge core_clk) disable iff (!arst_n)
         tag_one_frame |-> max_frame_len == LEN_TAG_ONE && !tag_two_frame;
   endproperty
   a_len_one: assert property (p_len_one)
      else $error("first tag limit wrong");
   property p_tag_two;
      @(posedge core_clk) disable iff (!arst_n)
         tag_lo_seen && {tag_hi, rx_data} == second_tag_identifier &&
         {tag_hi, rx_data} != first_tag_identifier |=> tag_two_frame;
   endproperty
   a_tag_two: assert property (p_tag_two)
      else $error("second tag match not flagged");
   property p_len_two;
      @(posedge core_clk) disable iff (!arst_n)
         tag_two_frame |-> max_frame_len == LEN_TAG_TWO;
   endproperty
   a_len_two: assert property (p_len_two)
      else $error("second tag limit wrong");
   property p_len_plain;
      @(posedge core_clk) disable iff (!arst_n)
         !tag_one_frame && !tag_two_frame |-> max_frame_len == LEN_PLAIN;
   endproperty
   a_len_plain: assert property (p_len_plain)
      else $error("untagged limit wrong");
   property p_ptr_step;
      @(posedge core_clk) disable iff (!arst_n)
         wr_en && reg_idx == IDX_WAKE_FILTER_LOAD && !digital_rst &&
         !soft_rst |=> filter_ptr == ($past(filter_ptr) ==
         PTR_W'(FILTER_DEPTH - 1) ? '0 : $past(filter_ptr) + PTR_W'(1));
   endproperty
   a_ptr_step: assert property (p_ptr_step)
      else $error("filter pointer did not step");
   property p_ptr_reset;
      @(posedge core_clk) disable iff (!arst_n)
         digital_rst || soft_rst |=> filter_ptr == '0;
   endproperty
   a_ptr_reset: assert property (p_ptr_reset)
      else $error("filter pointer not cleared");
   property p_filter_read;
      @(posedge core_clk) disable iff (!arst_n)
         wb_ack_o && !wb_we_i && reg_idx == IDX_WAKE_FILTER_LOAD |->
         wb_dat_o == 32'h0000_0000;
   endproperty
   a_filter_read: assert property (p_filter_read)
      else $error("filter location read not zero");
   property p_wframe_flag;
      @(posedge core_clk) disable iff (!arst_n)
         wake_frame_seen && wake_frame_detect_enable |=>
         wake_frame_received_flag && wake_request;
   endproperty
   a_wframe_flag: assert property (p_wframe_flag)
      else $error("wake frame flag not set");
   property p_magic_gate;
      @(posedge core_clk) disable iff (!arst_n)
         !magic_packet_received_flag && !magic_packet_wake_enable &&
         !(wr_en && reg_idx == IDX_WAKE_CONTROL_STATUS) |=>
         !magic_packet_received_flag;
   endproperty
   a_magic_gate: assert property (p_magic_gate)
      else $error("magic flag set while disabled");
   property p_unicast;
      @(posedge core_clk) disable iff (!arst_n)
         rx_valid && rx_last && global_unicast_wake_enable && !da_group_bit
         |=> wake_request && irq_status[IRQ_UNICAST];
   endproperty
   a_unicast: assert property (p_unicast)
      else $error("unicast wake missed");
   property p_tag_upper;
      @(posedge core_clk) disable iff (!arst_n)
         wb_ack_o && !wb_we_i && (reg_idx == IDX_VLAN_TAG_ONE ||
         reg_idx == IDX_VLAN_TAG_TWO) |-> wb_dat_o[31:16] == 16'h0000;
   endproperty
   a_tag_upper: assert property (p_tag_upper)
      else $error("tag upper bits not zero");
endmodule // hmvwf_core
`default_nettype wire

//--- hw/hmvwf_pkg.sv
// Constants for the host MAC tag and wake-up qualification block.
// Assumes a 32-bit classic Wishbone slave and a byte-wide receive stream.
package hmvwf_pkg;
   // Register indexes; byte address is four times the index
   localparam logic [5:0] IDX_VLAN_TAG_ONE = 6'h09;
   localparam logic [5:0] IDX_VLAN_TAG_TWO = 6'h0a;
   localparam logic [5:0] IDX_WAKE_FILTER_LOAD = 6'h0b;
   localparam logic [5:0] IDX_WAKE_CONTROL_STATUS = 6'h0c;
   localparam logic [5:0] IDX_IRQ_STATUS = 6'h0d;
   localparam logic [5:0] IDX_IRQ_MASK = 6'h0e;
   localparam int ADR_LSB = 2;

   // Tag registers
   localparam logic [15:0] TAG_RESET = 16'hffff;
   localparam int TAG_W = 16;

   // Wake control and status fields
   localparam int GUE_BIT = 9;
   localparam int WAKE_FRAME_RECEIVED_FLAG_BIT = 6;
   localparam int MPR_BIT = 5;
   localparam int WAKE_FRAME_DETECT_ENABLE_BIT = 2;
   localparam int MAGIC_PACKET_WAKE_ENABLE_BIT = 1;

   // Frame lengths in bytes
   localparam int LEN_W = 11;
   localparam logic [10:0] LEN_PLAIN = 11'h5ee;
   localparam logic [10:0] LEN_TAG_ONE = 11'h5f2;
   localparam logic [10:0] LEN_TAG_TWO = 11'h602;
   localparam logic [10:0] LEN_CAP = 11'h7ff;

   // Byte positions in a frame, counted from zero
   localparam logic [10:0] POS_DA_FIRST = 11'h000;
   localparam logic [10:0] POS_TAG_HI = 11'h00c;
   localparam logic [10:0] POS_TAG_LO = 11'h00d;

   // Interrupt status and mask layout
   localparam int IRQ_W = 4;
   localparam int IRQ_MAGIC = 0;
   localparam int IRQ_WAKE_FRAME = 1;
   localparam int IRQ_UNICAST = 2;
   localparam int IRQ_LEN_ERR = 3;
endpackage

//--- testbench/hmvwf_frame_src.sv
// Switch fabric side model: sends receive frames byte by byte.
// Assumes the core samples rx_valid, rx_data and rx_last on core_clk.
`timescale 1ns/10ps
`default_nettype none
module hmvwf_frame_src (
   input wire logic core_clk,
   output var logic rx_valid,
   output var logic [7:0] rx_data,
   output var logic rx_last
);
   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      rx_last = 1'b0;
   end

   // Byte 0 carries the address, bytes 12-13 the tag, high byte first
   task automatic send(input int len, input logic [7:0] da0,
                       input logic [15:0] tag, input bit slow);
      logic [7:0] b;
      b = 8'h00;
      for (int i = 0; i < len; i++) begin
         b = (i == 0) ? da0 : (i == 12) ? tag[15:8] :
             (i == 13) ? tag[7:0] : i[7:0] ^ 8'h5a;
         @(posedge core_clk);
         rx_valid <= 1'b1;
         rx_data <= b;
         rx_last <= (i == len - 1);
         if (slow && i != len - 1) begin
            @(posedge core_clk);
            rx_valid <= 1'b0;
            rx_data <= ~b;
         end
      end
      @(posedge core_clk);
      rx_valid <= 1'b0;
      rx_last <= 1'b0;
      // Released data line shows no stale byte
      rx_data <= ~b;
   endtask
endmodule // hmvwf_frame_src
`default_nettype wire

//--- testbench/test_host_mac_vlan_wakeup_filter.sv
// Testbench: register, frame and wake event sequences for the core.
// Assumes the core and the frame source model; one 100 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module test_host_mac_vlan_wakeup_filter;
   import hmvwf_pkg::*;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic digital_rst = 1'b0;
   logic soft_rst = 1'b0;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [7:0] wb_adr = 8'h00;
   logic [31:0] wb_dat = 32'h0;
   logic [31:0] wb_dat_o, rq;
   logic wb_ack_o, rx_valid, rx_last, ftl, wreq, irq, t1, t2, wde, mpe;
   logic mps = 1'b0;
   logic wfs = 1'b0;
   logic [7:0] rx_data;
   logic [LEN_W-1:0] mfl;
   logic [255:0] wfw;
   logic [10:0] lim [3];
   logic [15:0] tagv [3];
   int n_errors = 0;
   int n_checks = 0;

   always #5 core_clk = ~core_clk;

   hmvwf_core u_hmvwf_core (.core_clk(core_clk), .arst_n(arst_n),
      .digital_rst(digital_rst), .soft_rst(soft_rst), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_last(rx_last), .magic_packet_seen(mps), .wake_frame_seen(wfs),
      .tag_one_frame(t1), .tag_two_frame(t2), .max_frame_len(mfl),
      .frame_too_long(ftl), .wake_frame_detect_enable(wde),
      .magic_packet_wake_enable(mpe), .wake_filter_words(wfw),
      .wake_request(wreq), .irq(irq));

   hmvwf_frame_src u_hmvwf_frame_src (.core_clk(core_clk),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last));

   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Classic cycle; no latency assumed, only the watchdog ends a hang
   task automatic wb(input logic we, input logic [5:0] idx,
                     input logic [31:0] d);
      @(posedge core_clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= {idx, 2'b00};
      wb_dat <= d;
      do begin
         @(posedge core_clk);
      end while (wb_ack_o !== 1'b1);
      rq = wb_dat_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      // Write lands at this edge; callers look once it has settled
      #1;
   endtask

   task automatic rc(input logic [5:0] idx, input logic [31:0] e,
                     input string nm);
      wb(1'b0, idx, 32'h0);
      chk(nm, e, rq);
   endtask

   task automatic ev(input bit w, input logic e);
      @(posedge core_clk);
      if (w) wfs <= 1'b1;
      else mps <= 1'b1;
      @(posedge core_clk);
      wfs <= 1'b0;
      mps <= 1'b0;
      #1 chk("wake_request", e, wreq);
   endtask

   task automatic fr(input int len, input logic [7:0] da0,
                     input logic [15:0] tag, input logic [1:0] et);
      u_hmvwf_frame_src.send(len, da0, tag, len < 30);
      #1 chk("tag_flags", et, {t1, t2});
   endtask

   initial begin
      #500000;
      n_errors++;
      finish_test();
   end

   initial begin
      lim = '{LEN_TAG_ONE, LEN_TAG_TWO, LEN_PLAIN};
      tagv = '{16'h8100, 16'h88a8, 16'h0800};
      repeat (3) @(posedge core_clk);
      arst_n <= 1'b1;
      rc(IDX_VLAN_TAG_ONE, 32'hffff, "tag_one");
      rc(IDX_VLAN_TAG_TWO, 32'hffff, "tag_two");
      rc(IDX_WAKE_CONTROL_STATUS, 0, "wucsr");
      rc(6'h3f, 0, "unmapped");
      chk("len", LEN_PLAIN, mfl);
      chk("tag_flags", 0, {t1, t2});
      chk("irq", 0, irq);
      wb(1'b1, IDX_VLAN_TAG_ONE, 32'hffff8100);
      wb(1'b1, IDX_VLAN_TAG_TWO, 32'h123488a8);
      rc(IDX_VLAN_TAG_ONE, 32'h8100, "tag_one");
      rc(IDX_VLAN_TAG_TWO, 32'h88a8, "tag_two");
      $display("test registers done");
      fr(20, 8'h01, 16'h88a8, 2'b01);
      fr(20, 8'h01, 16'h8101, 2'b00);
      fr(20, 8'h01, 16'h0081, 2'b00);
      // Limit exactly met, then one byte over
      for (int k = 0; k < 3; k++) begin
         fr(lim[k], 8'h01, tagv[k], {k == 0, k == 1});
         chk("too_long", 0, ftl);
         chk("len", lim[k], mfl);
         fr(lim[k] + 1, 8'h01, tagv[k], {k == 0, k == 1});
         chk("too_long", 1, ftl);
      end
      wb(1'b1, IDX_VLAN_TAG_TWO, 32'h8100);
      fr(40, 8'h01, 16'h8100, 2'b10);
      chk("len", LEN_TAG_ONE, mfl);
      wb(1'b1, IDX_VLAN_TAG_TWO, 32'h88a8);
      $display("test tags done");
      rc(IDX_IRQ_STATUS, 32'h8, "irq_status");
      wb(1'b1, IDX_IRQ_MASK, 32'hf);
      chk("irq", 1, irq);
      wb(1'b1, IDX_IRQ_MASK, 32'h0);
      chk("irq", 0, irq);
      wb(1'b1, IDX_IRQ_STATUS, 32'h8);
      rc(IDX_IRQ_STATUS, 0, "irq_status");
      $display("test interrupt done");
      ev(1'b0, 1'b0);
      ev(1'b1, 1'b0);
      rc(IDX_WAKE_CONTROL_STATUS, 0, "wucsr");
      wb(1'b1, IDX_WAKE_CONTROL_STATUS, 32'h6);
      chk("enables", 2'b11, {wde, mpe});
      ev(1'b0, 1'b1);
      ev(1'b1, 1'b1);
      rc(IDX_WAKE_CONTROL_STATUS, 32'h66, "wucsr");
      wb(1'b1, IDX_WAKE_CONTROL_STATUS, 32'h26);
      rc(IDX_WAKE_CONTROL_STATUS, 32'h46, "wucsr");
      wb(1'b1, IDX_WAKE_CONTROL_STATUS, 32'h46);
      rc(IDX_WAKE_CONTROL_STATUS, 32'h06, "wucsr");
      rc(IDX_IRQ_STATUS, 32'h3, "irq_status");
      wb(1'b1, IDX_IRQ_STATUS, 32'h3);
      wb(1'b1, IDX_WAKE_CONTROL_STATUS, 32'h200);
      fr(64, 8'h02, 16'h0800, 2'b00);
      chk("wake_request", 1, wreq);
      fr(64, 8'h03, 16'h0800, 2'b00);
      chk("wake_request", 0, wreq);
      rc(IDX_IRQ_STATUS, 32'h4, "irq_status");
      $display("test wake done");
      // Nine writes: the ninth lands in entry zero again
      for (int g = 0; g < 9; g++)
         wb(1'b1, IDX_WAKE_FILTER_LOAD, 32'h10000000 + g);
      for (int g = 0; g < 8; g++)
         chk("filter", g ? 32'h10000000 + g : 32'h10000008,
             wfw[g*32 +: 32]);
      rc(IDX_WAKE_FILTER_LOAD, 0, "filter_read");
      @(posedge core_clk) soft_rst <= 1'b1;
      @(posedge core_clk) soft_rst <= 1'b0;
      wb(1'b1, IDX_WAKE_FILTER_LOAD, 32'haaaa0001);
      chk("filter", 32'haaaa0001, wfw[31:0]);
      @(posedge core_clk) digital_rst <= 1'b1;
      @(posedge core_clk) digital_rst <= 1'b0;
      wb(1'b1, IDX_WAKE_FILTER_LOAD, 32'hbbbb0002);
      chk("filter", 32'hbbbb0002, wfw[31:0]);
      chk("filter", 32'h10000001, wfw[63:32]);
      $display("test filter done");
      finish_test();
   end
endmodule // test_host_mac_vlan_wakeup_filter
`default_nettype wire
